// [verilog/cpu_core_pkg.sv]
package cpu_core_pkg;

  // Address space and reset entry
  localparam int         ADDR_W      = 14;
  localparam logic [13:0] RESET_PC   = 14'h3FFD;  // Fetch starts here after reset
  localparam logic [13:0] XWIN_ADDR  = 14'h000E;  // Indexed data window
  localparam logic [13:0] XREG_ADDR  = 14'h000F;  // Index byte in memory
  localparam logic [5:0]  DIR_HIGH   = 6'h00;     // Direct page high part
  localparam logic [9:0]  TINY_HIGH  = 10'h000;   // Ten leading zeros for tiny mode
  localparam logic [3:0]  TINY_GROUP = 4'h6;      // Upper nibble of tiny add

  // Opcodes
  localparam logic [7:0] OP_ADC_IMM = 8'hA9;
  localparam logic [7:0] OP_ADC_DIR = 8'hB9;
  localparam logic [7:0] OP_ADD_IMM = 8'hAB;
  localparam logic [7:0] OP_ADD_DIR = 8'hBB;
  localparam logic [7:0] OP_AND_IMM = 8'hA4;
  localparam logic [7:0] OP_AND_DIR = 8'hB4;
  localparam logic [7:0] OP_ACC_SHIFT_LEFT_OP    = 8'h48;
  localparam logic [7:0] OP_BRA     = 8'h30;
  localparam logic [7:0] OP_BCC     = 8'h34;
  localparam logic [7:0] OP_BCS     = 8'h35;
  localparam logic [7:0] OP_BNE     = 8'h36;
  localparam logic [7:0] OP_BEQ     = 8'h37;
  localparam logic [7:0] OP_BGND    = 8'hBF;
  localparam logic [7:0] OP_WAIT    = 8'hAC;
  localparam logic [7:0] OP_STOP    = 8'hAE;
  localparam logic [7:0] OP_JMP     = 8'hBC;
  localparam logic [7:0] OP_JSR     = 8'hBD;

  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PC     = 4'h8;
  localparam logic [3:0] REG_ACC    = 4'hC;

  // Field positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_HALT_BIT = 1;
  localparam int ST_Z_BIT      = 2;
  localparam int ST_C_BIT      = 3;
  localparam int ST_WAKE_BIT   = 4;
  localparam int PC_SHADOW_LSB = 16;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Run modes as seen in the status register
  localparam logic [1:0] MODE_RUN  = 2'h0;
  localparam logic [1:0] MODE_WAIT = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_BGND = 2'h3;

  // Core sequencer states
  typedef enum logic [3:0] {
    ST_FETCH, ST_EXEC, ST_IMM, ST_DIRA, ST_TPAD, ST_XRD, ST_DATA,
    ST_REL, ST_EXTH, ST_EXTL, ST_LOWPWR, ST_BGND
  } cpu_state_t;

  // Arithmetic kinds
  typedef enum logic [1:0] {ALU_ADC, ALU_ADD, ALU_AND} alu_kind_t;

endpackage

// [verilog/tiny_cpu_decode_lowpower.sv]
// Function
// - WAIT enters wait, STOP enters stop
// - Low power suspends core until wake or reset
// - Background mode idles awaiting debug commands
// - Shift left opcode 48, one cycle, both flags
// - PC is 6-bit high, 8-bit low
// - Shadow PC split the same way
// - Index byte lives at memory 000F
// - Access to 000E goes through index byte
// - Direct operand gives low byte, high zero
// - Extended address from two bytes, 14 bits
// - Tiny operand: low four opcode bits
// - Branch offset signed byte from next address
// - Flags are only zero and carry
// - ADC: A9 two cycles, B9 three, four when the operand is 0E
// - ADD: AB, BB, 6x tiny forms
// - AND: A4, B4, zero flag only
// - Interrupts only wake, never divert flow
// - Tiny address gets ten leading zeros
`timescale 1ns/1ps
module tiny_cpu_decode_lowpower
  import cpu_core_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // Memory side, asynchronous read
  output logic [13:0]      MEM_ADDR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  // Pins
  input  wire logic        WAKE_IRQ,
  input  wire logic        BKGD_REQ,
  output logic             CPU_CLK_EN,
  output logic             WAIT_MODE,
  output logic             STOP_MODE,
  output logic             BGND_ACTIVE,
  // AXI4-Lite slave
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // Pin synchronisers: three stages per pin, filtered level after
  logic [1:0]  sync1;           // First stage, read only by sync2
  logic [1:0]  sync2;           // Second stage
  logic [1:0]  sync3;           // Third stage
  logic [1:0]  pin_lvl;         // Accepted level
  wire  [1:0]  pin_raw = {BKGD_REQ, WAKE_IRQ};

  // Core registers
  cpu_state_t  state;           // Sequencer state
  logic [5:0]  pc_high_part;    // Upper PC bits
  logic [7:0]  pc_low_part;     // Lower PC bits
  logic [5:0]  shadow_pc_high;  // Upper shadow bits
  logic [7:0]  shadow_pc_low;   // Lower shadow bits
  logic [7:0]  acc;             // Accumulator
  logic        zf;              // Zero indicator
  logic        cf;              // Carry/borrow indicator
  logic [7:0]  opcode;          // Instruction being executed
  logic [7:0]  ext_high;        // First extended byte
  logic        stop_kind;       // Low power kind: 1 stop, 0 wait
  logic [13:0] mem_addr;        // Registered memory address
  logic        mem_rd;          // Registered read strobe

  // Next values
  cpu_state_t  next_state;
  logic [13:0] next_pc;
  logic [13:0] next_spc;
  logic [7:0]  next_acc;
  logic        next_zf;
  logic        next_cf;
  logic [7:0]  next_opcode;
  logic [7:0]  next_ext_high;
  logic        next_stop_kind;
  logic [13:0] next_addr;
  logic        next_rd;
  logic        do_finish;       // Instruction boundary reached

  // Bus side registers
  logic        aw_held;         // Write address captured
  logic [3:0]  aw_addr;
  logic        w_held;          // Write data captured
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        halt_req;        // Sticky background request from software
  logic [31:0] rdata;

  // Program counter is two parts glued together
  wire [13:0] pc_full  = {pc_high_part, pc_low_part};
  wire [13:0] spc_full = {shadow_pc_high, shadow_pc_low};

  // Opcode classes
  wire is_imm  = (MEM_RDATA == OP_ADC_IMM) || (MEM_RDATA == OP_ADD_IMM) || (MEM_RDATA == OP_AND_IMM);
  wire is_dir  = (MEM_RDATA == OP_ADC_DIR) || (MEM_RDATA == OP_ADD_DIR) || (MEM_RDATA == OP_AND_DIR);
  wire is_tny  = (MEM_RDATA[7:4] == TINY_GROUP);
  wire is_rel  = (MEM_RDATA == OP_BRA) || (MEM_RDATA == OP_BCC) || (MEM_RDATA == OP_BCS)
              || (MEM_RDATA == OP_BNE) || (MEM_RDATA == OP_BEQ);
  wire is_ext  = (MEM_RDATA == OP_JMP) || (MEM_RDATA == OP_JSR);

  // Arithmetic selection from the held opcode
  wire alu_kind_t alu_kind = ((opcode == OP_ADC_IMM) || (opcode == OP_ADC_DIR)) ? ALU_ADC :
                             ((opcode == OP_AND_IMM) || (opcode == OP_AND_DIR)) ? ALU_AND : ALU_ADD;
  wire        carry_in = (alu_kind == ALU_ADC) ? cf : 1'b0;
  wire [8:0]  sum9     = {1'b0, acc} + {1'b0, MEM_RDATA} + {8'h00, carry_in};
  wire [7:0]  and8     = acc & MEM_RDATA;
  wire [7:0]  alu_res  = (alu_kind == ALU_AND) ? and8 : sum9[7:0];

  // Address formation
  wire [13:0] tiny_addr = {TINY_HIGH, opcode[3:0]};
  wire [13:0] dir_addr  = {DIR_HIGH, MEM_RDATA};
  wire [13:0] rel_off   = {{6{MEM_RDATA[7]}}, MEM_RDATA};

  // Branch conditions on the held opcode
  wire br_taken = (opcode == OP_BRA)
               || ((opcode == OP_BCC) && !cf) || ((opcode == OP_BCS) && cf)
               || ((opcode == OP_BNE) && !zf) || ((opcode == OP_BEQ) && zf);

  // Background is entered at a boundary by pin, software or opcode
  wire bgnd_pend = pin_lvl[1] || halt_req;

  // Register bus decode
  wire wr_fire   = aw_held && w_held && !S_AXI_BVALID;
  wire wr_ctrl   = wr_fire && (aw_addr == REG_CTRL);
  wire wr_pc     = wr_fire && (aw_addr == REG_PC) && (state == ST_BGND);
  wire wr_acc    = wr_fire && (aw_addr == REG_ACC) && (state == ST_BGND);
  wire wr_known  = (aw_addr == REG_CTRL) || (aw_addr == REG_STATUS)
                || (aw_addr == REG_PC) || (aw_addr == REG_ACC);
  wire go_cmd    = wr_ctrl && w_strb[0] && w_data[CTRL_GO_BIT];
  wire halt_cmd  = wr_ctrl && w_strb[0] && w_data[CTRL_HALT_BIT];
  wire rd_fire   = S_AXI_ARVALID && !S_AXI_RVALID;
  wire [3:0] ar_a = S_AXI_ARADDR[3:0];
  wire rd_known  = (S_AXI_ARADDR[31:4] == 28'h0000000) && (ar_a[1:0] == 2'h0);
  wire [1:0] mode = (state == ST_BGND) ? MODE_BGND :
                    (state != ST_LOWPWR) ? MODE_RUN : (stop_kind ? MODE_STOP : MODE_WAIT);

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Read mux; unmapped words read as zero with an error answer
  always_comb
  begin
    rdata = 32'h00000000;
    case (ar_a)
      REG_STATUS: rdata = {27'h0000000, pin_lvl[0], cf, zf, mode};
      REG_PC:     rdata = {2'h0, spc_full, 2'h0, pc_full};
      REG_ACC:    rdata = {24'h000000, acc};
      default:    rdata = 32'h00000000;
    endcase
  end

  // Three flops per pin; accept a level once stages two and three agree
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1   <= 2'h0;
      sync2   <= 2'h0;
      sync3   <= 2'h0;
      pin_lvl <= 2'h0;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 2; i++)
        if (sync2[i] == sync3[i])
          pin_lvl[i] <= sync3[i];
    end
  end

  // Sequencer: paths end in a boundary that issues the next fetch, or enters background if a request is pending; the go that leaves background always fetches
  always_comb
  begin
    next_state     = state;
    next_pc        = pc_full;
    next_spc       = spc_full;
    next_acc       = acc;
    next_zf        = zf;
    next_cf        = cf;
    next_opcode    = opcode;
    next_ext_high  = ext_high;
    next_stop_kind = stop_kind;
    next_addr      = mem_addr;
    next_rd        = 1'b0;
    do_finish      = 1'b0;
    case (state)
      ST_FETCH:
        do_finish = 1'b1;
      ST_EXEC:
      begin
        next_opcode = MEM_RDATA;
        if (MEM_RDATA == OP_ACC_SHIFT_LEFT_OP)
        begin
          // Same as logical shift left; carry takes bit 7
          next_cf   = acc[7];
          next_acc  = {acc[6:0], 1'b0};
          next_zf   = (acc[6:0] == 7'h00);
          do_finish = 1'b1;
        end
        else if (is_imm || is_dir || is_rel || is_ext)
        begin
          // Operand byte follows the opcode
          next_addr  = pc_full;
          next_rd    = 1'b1;
          next_pc    = pc_full + 14'h0001;
          next_state = is_imm ? ST_IMM : is_dir ? ST_DIRA : is_rel ? ST_REL : ST_EXTH;
        end
        else if (is_tny)
        begin
          // Window form reads the index byte at once, so it costs no more than 3 cycles
          next_rd    = ({TINY_HIGH, MEM_RDATA[3:0]} == XWIN_ADDR);
          next_addr  = XREG_ADDR;
          next_state = next_rd ? ST_XRD : ST_TPAD;
        end
        else if ((MEM_RDATA == OP_WAIT) || (MEM_RDATA == OP_STOP))
        begin
          // PC already points past this opcode, so wake resumes there
          next_stop_kind = (MEM_RDATA == OP_STOP);
          next_state     = ST_LOWPWR;
        end
        else if (MEM_RDATA == OP_BGND)
          next_state = ST_BGND;
        else
          do_finish = 1'b1;  // Unlisted opcodes run as one-cycle no-ops
      end
      ST_TPAD:
      begin
        // Spare cycle keeps tiny adds at their three-cycle cost
        next_rd    = 1'b1;
        next_addr  = tiny_addr;
        next_state = ST_DATA;
      end
      ST_DIRA:
      begin
        next_rd    = 1'b1;
        next_addr  = (dir_addr == XWIN_ADDR) ? XREG_ADDR : dir_addr;
        next_state = (dir_addr == XWIN_ADDR) ? ST_XRD : ST_DATA;
      end
      ST_XRD:
      begin
        // Index byte in hand: its value picks the direct-page location
        next_rd    = 1'b1;
        next_addr  = dir_addr;
        next_state = ST_DATA;
      end
      ST_IMM, ST_DATA:
      begin
        next_acc = alu_res;
        next_zf  = (alu_res == 8'h00);
        if (alu_kind != ALU_AND)
          next_cf = sum9[8];
        do_finish = 1'b1;
      end
      ST_REL:
      begin
        if (br_taken)
          next_pc = pc_full + rel_off;
        do_finish = 1'b1;
      end
      ST_EXTH:
      begin
        next_ext_high = MEM_RDATA;
        next_addr     = pc_full;
        next_rd       = 1'b1;
        next_pc       = pc_full + 14'h0001;
        next_state    = ST_EXTL;
      end
      ST_EXTL:
      begin
        if (opcode == OP_JSR)
          next_spc = pc_full;
        next_pc   = {ext_high[5:0], MEM_RDATA};
        do_finish = 1'b1;
      end
      ST_LOWPWR:
        // Only the wake level leaves; the interrupt does not vector anywhere
        do_finish = pin_lvl[0];
      ST_BGND:
        do_finish = go_cmd;
      default:
        next_state = ST_FETCH;
    endcase
    if (do_finish)
    begin
      if (bgnd_pend && (state != ST_BGND))
        next_state = ST_BGND;
      else
      begin
        next_addr  = next_pc;
        next_rd    = 1'b1;
        next_pc    = next_pc + 14'h0001;
        next_state = ST_EXEC;
      end
    end
    if (wr_pc)
      next_pc = w_data[13:0];
    if (wr_acc)
      next_acc = w_data[7:0];
  end

  // Core state update
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state          <= ST_FETCH;
      pc_high_part   <= RESET_PC[13:8];
      pc_low_part    <= RESET_PC[7:0];
      shadow_pc_high <= 6'h00;
      shadow_pc_low  <= 8'h00;
      acc            <= 8'h00;
      zf             <= 1'b0;
      cf             <= 1'b0;
      opcode         <= 8'h00;
      ext_high       <= 8'h00;
      stop_kind      <= 1'b0;
      mem_addr       <= 14'h0000;
      mem_rd         <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      pc_high_part   <= next_pc[13:8];
      pc_low_part    <= next_pc[7:0];
      shadow_pc_high <= next_spc[13:8];
      shadow_pc_low  <= next_spc[7:0];
      acc            <= next_acc;
      zf             <= next_zf;
      cf             <= next_cf;
      opcode         <= next_opcode;
      ext_high       <= next_ext_high;
      stop_kind      <= next_stop_kind;
      mem_addr       <= next_addr;
      mem_rd         <= next_rd;
    end
  end

  // Mode pins come from flops so they never glitch
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CPU_CLK_EN  <= 1'b1;
      WAIT_MODE   <= 1'b0;
      STOP_MODE   <= 1'b0;
      BGND_ACTIVE <= 1'b0;
    end
    else
    begin
      // Clock gating itself lives in the clock tree; this is its request
      CPU_CLK_EN  <= (next_state != ST_LOWPWR);
      WAIT_MODE   <= (next_state == ST_LOWPWR) && !next_stop_kind;
      STOP_MODE   <= (next_state == ST_LOWPWR) && next_stop_kind;
      BGND_ACTIVE <= (next_state == ST_BGND);
    end
  end

  // Bus slave: address and data captured independently, then one answer
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 4'h0;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= RESP_OKAY;
      halt_req     <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_held)
      begin
        aw_held <= 1'b1;
        // Upper address bits must be zero and aligned, else flag as unmapped
        aw_addr <= ((S_AXI_AWADDR[31:4] == 28'h0000000) && (S_AXI_AWADDR[1:0] == 2'h0))
                   ? S_AXI_AWADDR[3:0] : 4'h1;
      end
      if (S_AXI_WVALID && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (rd_fire)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_known ? rdata : 32'h00000000;
        S_AXI_RRESP  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      // Request set wins over the clear on entry
      if (halt_cmd)
        halt_req <= 1'b1;
      else if (next_state == ST_BGND)
        halt_req <= 1'b0;
    end
  end

  assign MEM_ADDR = mem_addr;
  assign MEM_RD   = mem_rd;

endmodule // tiny_cpu_decode_lowpower

// [dv/cpu_mem_model.sv]
`timescale 1ns/1ps
module cpu_mem_model
(
  input  wire logic        clk,
  input  wire logic [13:0] addr,
  input  wire logic        rd,
  output logic [7:0]       rdata
);
  logic [7:0] mem [0:16383];  // Whole map; the index byte at 000F is plain memory here
  logic [7:0] last;           // Last byte handed out

  // Asynchronous read; an idle bus shows the inverse so stale data never looks valid
  assign rdata = rd ? mem[addr] : ~last;

  // Remember what was driven
  always @(posedge clk)
  begin
    if (rd)
      last <= mem[addr];
  end

  // Unloaded space holds a harmless no-op
  initial
  begin
    last = 8'h00;
    foreach (mem[i])
      mem[i] = 8'h00;
  end
endmodule // cpu_mem_model

// [dv/tiny_cpu_decode_lowpower_asserts.sv]
`timescale 1ns/1ps
module tiny_cpu_decode_lowpower_asserts
  import cpu_core_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic [13:0] MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        WAKE_IRQ,
  input wire logic        CPU_CLK_EN,
  input wire logic        WAIT_MODE,
  input wire logic        STOP_MODE,
  input wire logic        BGND_ACTIVE,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  wire sleeping;  // Either low-power mode
  assign sleeping = WAIT_MODE || STOP_MODE;

  // Asleep with no wake request
  sequence s_quiet;
    sleeping && !WAKE_IRQ;
  endsequence
  // The cycle the core wakes
  sequence s_woken;
    $fell(sleeping);
  endsequence

  property p_modes_excl;
    $onehot0({WAIT_MODE, STOP_MODE, BGND_ACTIVE});
  endproperty
  a_modes_excl: assert property (p_modes_excl) else $error("Two halt modes at once");
  property p_lp_gated;
    sleeping |-> !CPU_CLK_EN && !MEM_RD;
  endproperty
  a_lp_gated: assert property (p_lp_gated) else $error("Core active while asleep");
  property p_lp_hold;
    s_quiet [*5] |=> sleeping;
  endproperty
  a_lp_hold: assert property (p_lp_hold) else $error("Woke without request");
  property p_wake_bound;
    sleeping && WAKE_IRQ |-> ##[1:8] !sleeping;
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("Wake request ignored");
  property p_wake_resume;
    s_woken |-> ##[0:1] (MEM_RD && CPU_CLK_EN);
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("No fetch after wake");
  property p_bgnd_idle;
    BGND_ACTIVE && $past(BGND_ACTIVE) |-> !MEM_RD;
  endproperty
  a_bgnd_idle: assert property (p_bgnd_idle) else $error("Fetch in background");
  property p_no_window;
    MEM_RD |-> MEM_ADDR != XWIN_ADDR;
  endproperty
  a_no_window: assert property (p_no_window) else $error("Window read not redirected");
  property p_rd_answer;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read not answered");
  property p_rd_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("Read data dropped");
  property p_wr_answer;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("Write not answered");
endmodule // tiny_cpu_decode_lowpower_asserts

bind tiny_cpu_decode_lowpower tiny_cpu_decode_lowpower_asserts i_tiny_cpu_decode_lowpower_asserts
(
  .MCLK(MCLK), .RST_N(RST_N), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .WAKE_IRQ(WAKE_IRQ),
  .CPU_CLK_EN(CPU_CLK_EN), .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE), .BGND_ACTIVE(BGND_ACTIVE),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY)
);

// [dv/test_tiny_cpu_decode_lowpower.sv]
`timescale 1ns/1ps
module test_tiny_cpu_decode_lowpower
  import cpu_core_pkg::*;
();
  logic        mclk, rst_n, wake, bkgd, mem_rd, clk_en, wait_m, stop_m, bgnd;
  logic [13:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          miscompares, samples_checked, cyc, rd_count;
  int          seen [int];  // First read cycle of each address

  tiny_cpu_decode_lowpower i_tiny_cpu_decode_lowpower
  (
    .MCLK(mclk), .RST_N(rst_n), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
    .WAKE_IRQ(wake), .BKGD_REQ(bkgd), .CPU_CLK_EN(clk_en), .WAIT_MODE(wait_m), .STOP_MODE(stop_m),
    .BGND_ACTIVE(bgnd), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  cpu_mem_model i_cpu_mem_model (.clk(mclk), .addr(mem_addr), .rd(mem_rd), .rdata(mem_rdata));

  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Fetch timing monitor: cycle counts come from first-read stamps
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (mem_rd === 1'b1)
    begin
      rd_count = rd_count + 1;
      if (!seen.exists(mem_addr))
        seen[mem_addr] = cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    chk(bresp, RESP_OKAY);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic load(input logic [13:0] a, input logic [7:0] p[]);
    foreach (p[i])
      i_cpu_mem_model.mem[a + i] = p[i];
  endtask

  // Set PC and accumulator from background, then release the core
  task automatic start(input logic [13:0] pc, input logic [7:0] acc);
    seen.delete();
    wr({28'h0, REG_PC}, {18'h0, pc});
    wr({28'h0, REG_ACC}, {24'h0, acc});
    wr({28'h0, REG_CTRL}, 32'h1);
  endtask

  task automatic wait_bgnd();
    @(posedge mclk);
    while (bgnd !== 1'b1)
      @(posedge mclk);
  endtask

  task automatic expect_state(input logic [7:0] acc, input logic z, input logic c);
    logic [31:0] d;
    logic [1:0]  r;
    rd({28'h0, REG_ACC}, d, r);
    chk(d, {24'h0, acc});
    rd({28'h0, REG_STATUS}, d, r);
    chk(d[3:0], {c, z, MODE_BGND});
  endtask

  function automatic int span(input int a, input int b);
    return seen[b] - seen[a];
  endfunction

  // Held in background by the pin: no fetching, plus an unmapped read
  task automatic t_bgnd_idle();
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    wait_bgnd();
    n = rd_count;
    repeat (20) @(posedge mclk);
    chk(rd_count, n);
    chk(seen.exists(RESET_PC), 32'h1);
    rd(32'h10, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    bkgd <= 1'b0;
  endtask

  // Immediate forms and shift; AND must keep the carry for the ADC
  task automatic t_alu_imm();
    load(14'h0040, '{8'hAB, 8'h20, 8'hA4, 8'h1F, 8'hA9, 8'hF0, 8'h48, 8'hBF});
    start(14'h0040, 8'hF0);
    wait_bgnd();
    expect_state(8'h02, 1'b0, 1'b0);
    chk(span(14'h40, 14'h42), 32'h2);
    chk(span(14'h42, 14'h44), 32'h2);
    chk(span(14'h44, 14'h46), 32'h2);
    chk(span(14'h46, 14'h47), 32'h1);
    load(14'h0060, '{8'h48, 8'hBF});
    start(14'h0060, 8'h80);
    wait_bgnd();
    expect_state(8'h00, 1'b1, 1'b1);
  endtask

  // Direct, tiny, index byte and window forms from a high page
  task automatic t_addr_modes();
    load(14'h0005, '{8'h03});
    load(14'h000F, '{8'h30});
    load(14'h0030, '{8'h07});
    load(14'h1F50, '{8'hBB, 8'h05, 8'h65, 8'h6E, 8'hB9, 8'h0F, 8'hB4, 8'h0E, 8'hBF});
    start(14'h1F50, 8'h01);
    wait_bgnd();
    expect_state(8'h06, 1'b0, 1'b0);
    chk(span(14'h1F50, 14'h1F52), 32'h3);
    chk(span(14'h1F52, 14'h1F53), 32'h3);
    chk(span(14'h1F53, 14'h1F54), 32'h3);
    chk(span(14'h1F54, 14'h1F56), 32'h3);
    chk(span(14'h1F56, 14'h1F58), 32'h4);
  endtask

  // Extended call, then branches at both ends of the offset range, then a software halt
  task automatic t_branch_ext();
    logic [31:0] d;
    logic [1:0]  r;
    load(14'h0100, '{8'hBD, 8'h12, 8'h34});
    load(14'h1234, '{8'h30, 8'h7F});
    load(14'h12B5, '{8'h30, 8'h80});
    load(14'h1237, '{8'hBF});
    start(14'h0100, 8'h00);
    wait_bgnd();
    chk(span(14'h0100, 14'h1234), 32'h3);
    chk(seen.exists(14'h12B5), 32'h1);
    chk(seen.exists(14'h1237), 32'h1);
    rd({28'h0, REG_PC}, d, r);
    chk(d[29:16], 14'h0103);
    chk(d[13:0], 14'h1238);
    load(14'h0300, '{8'h30, 8'hFE});
    start(14'h0300, 8'h00);
    wr({28'h0, REG_CTRL}, 32'h2);
    wait_bgnd();
    rd({28'h0, REG_PC}, d, r);
    chk(d[13:0], 14'h0300);
  endtask

  // Wait, then stop; each held until a wake, resuming after the instruction
  task automatic t_low_power();
    int n;
    load(14'h0200, '{8'hAC, 8'hAB, 8'h01, 8'hAB, 8'h01, 8'hAB, 8'h01, 8'hAB, 8'h01,
                     8'hAE, 8'hAB, 8'h01, 8'hBF});
    start(14'h0200, 8'h00);
    while (wait_m !== 1'b1)
      @(posedge mclk);
    n = rd_count;
    repeat (20) @(posedge mclk);
    chk({wait_m, stop_m, clk_en}, 32'h4);
    chk(rd_count, n);
    wake <= 1'b1;
    while (wait_m !== 1'b0)
      @(posedge mclk);
    wake <= 1'b0;
    while (stop_m !== 1'b1)
      @(posedge mclk);
    chk(seen.exists(14'h0201), 32'h1);
    n = rd_count;
    repeat (20) @(posedge mclk);
    chk({wait_m, stop_m, clk_en}, 32'h2);
    chk(rd_count, n);
    wake <= 1'b1;
    wait_bgnd();
    expect_state(8'h05, 1'b0, 1'b0);
    wake <= 1'b0;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    {rst_n, wake, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    {miscompares, samples_checked, cyc, rd_count} = '0;
    bkgd = 1'b1;
    repeat (20) @(posedge mclk);
    load(RESET_PC, '{8'hBF});
    rst_n <= 1'b1;
    t_bgnd_idle();
    t_alu_imm();
    t_addr_modes();
    t_branch_ext();
    t_low_power();
    wrap_up();
  end
endmodule // test_tiny_cpu_decode_lowpower
